// ===== dv/sbd_decode_timing_monitor.sv
// ***********************************************
// decode and timing checks
// ***********************************************
module sbd_decode_timing_monitor #(
  parameter ADDR_W = 16
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              fetchReady,
  input wire logic              busWait,
  input wire logic              decodeValid,
  input wire logic              isAnd,
  input wire logic              isShortJump,
  input wire logic              jumpTaken,
  input wire logic [ADDR_W-1:0] jumpTarget,
  input wire logic [3:0]        execClocks,
  input wire logic              unsupported,
  input wire logic              instrDone,
  input wire logic [7:0]        elapsedClocks,
  input wire logic              busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] elapsedReg;
  logic [3:0] nonWaitReg;

  // exec cycles and the non-wait part of them
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      elapsedReg <= 8'h00;
      nonWaitReg <= 4'h0;
    end
    else if (decodeValid)
    begin
      elapsedReg <= 8'h01;
      nonWaitReg <= {3'h0, !busWait};
    end
    else if (!fetchReady)
    begin
      elapsedReg <= elapsedReg + 8'h01;
      nonWaitReg <= nonWaitReg + {3'h0, !busWait};
    end
  end

  sequence s_taken_even;
    decodeValid && jumpTaken && isShortJump && !jumpTarget[0] && !busWait ##1 !busWait [*3];
  endsequence

  pulse_once_a: assert property (decodeValid |=> !decodeValid && !unsupported)
    else $error("decode pulse longer than one cycle");
  and_clocks_a: assert property (decodeValid && isAnd |-> execClocks == 4'h1 && !isShortJump)
    else $error("and decode count wrong");
  fall_clocks_a: assert property (decodeValid && isShortJump && !jumpTaken |-> execClocks == 4'h1)
    else $error("fall through count wrong");
  taken_clocks_a: assert property (decodeValid && jumpTaken |-> execClocks == 4'h4 + {3'h0, jumpTarget[0]})
    else $error("taken count wrong");
  exec_hold_a: assert property (decodeValid |-> !fetchReady && busy)
    else $error("fetch not held during execution");
  done_count_a: assert property (instrDone |-> elapsedClocks == elapsedReg)
    else $error("elapsed count wrong");
  done_exec_a: assert property (instrDone |-> nonWaitReg == execClocks)
    else $error("done at wrong cycle");
  taken_done_a: assert property (s_taken_even |=> instrDone)
    else $error("taken jump not done in four clocks");
  taken_hold_a: assert property (decodeValid && jumpTaken |=> !instrDone [*3])
    else $error("taken jump done early");
  unsup_idle_a: assert property (unsupported |-> fetchReady && !busy && !decodeValid)
    else $error("refused byte left block busy");
endmodule // sbd_decode_timing_monitor

bind sbd_decode_timing sbd_decode_timing_monitor #(.ADDR_W(ADDR_W)) mon_i (
  .ref_clk(ref_clk), .rst(rst), .fetchReady(fetchReady), .busWait(busWait),
  .decodeValid(decodeValid), .isAnd(isAnd), .isShortJump(isShortJump),
  .jumpTaken(jumpTaken), .jumpTarget(jumpTarget), .execClocks(execClocks),
  .unsupported(unsupported), .instrDone(instrDone), .elapsedClocks(elapsedClocks), .busy(busy));

// ===== dv/sbd_decode_timing_test.sv
module sbd_decode_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        carryFlag = 1'b0, zeroFlag = 1'b0, signFlag = 1'b0;
  logic        overflowFlag = 1'b0, parityFlag = 1'b0, busWait = 1'b0;
  logic [15:0] loopCountRegister = 16'h0000, addr, tgt;
  wire         fetchValid, fetchReady, decodeValid, isAnd, andWide, andToFirstReg;
  wire         isShortJump, jumpTaken, unsupported, instrDone, busy;
  wire [7:0]   fetchByte, elapsedClocks;
  wire [15:0]  fetchAddr, jumpTarget;
  wire [2:0]   andRegHi, andRegLo;
  wire [3:0]   execClocks;
  logic [31:0] decQ[$], r, r2;
  logic [7:0]  doneQ[$], op, b1;
  logic [3:0]  ec;
  logic        tk;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0, i, t;
  integer      seed = 32'hF89CD684;

  initial forever #12.5 ref_clk = ~ref_clk;

  sbd_fetch_model sbd_fetch_model_i (.ref_clk(ref_clk), .rst(rst), .fetchReady(fetchReady),
    .fetchValid(fetchValid), .fetchByte(fetchByte), .fetchAddr(fetchAddr));
  sbd_decode_timing sbd_decode_timing_i (.ref_clk(ref_clk), .rst(rst), .fetchValid(fetchValid),
    .fetchByte(fetchByte), .fetchAddr(fetchAddr), .fetchReady(fetchReady), .carryFlag(carryFlag),
    .zeroFlag(zeroFlag), .signFlag(signFlag), .overflowFlag(overflowFlag),
    .parityFlag(parityFlag), .loopCountRegister(loopCountRegister), .busWait(busWait),
    .decodeValid(decodeValid), .isAnd(isAnd), .andWide(andWide), .andToFirstReg(andToFirstReg),
    .andRegHi(andRegHi), .andRegLo(andRegLo), .isShortJump(isShortJump), .jumpTaken(jumpTaken),
    .jumpTarget(jumpTarget), .execClocks(execClocks), .unsupported(unsupported),
    .instrDone(instrDone), .elapsedClocks(elapsedClocks), .busy(busy));

  // ***********************************************
  // reference and compare
  // ***********************************************
  function automatic logic taken(input logic [7:0] o);
    logic b;
    case (o[3:1])
      3'h0: b = overflowFlag;
      3'h1: b = carryFlag;
      3'h2: b = zeroFlag;
      3'h3: b = carryFlag | zeroFlag;
      3'h4: b = signFlag;
      3'h5: b = parityFlag;
      3'h6: b = signFlag ^ overflowFlag;
      default: b = (signFlag ^ overflowFlag) | zeroFlag;
    endcase
    taken = (o == 8'hE3) ? (loopCountRegister == 16'h0000) : b ^ o[0];
  endfunction

  task cmp_decode(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("Error at %0t: decode got %h expected %h", $time, got, want);
    end
  endtask

  task cmp_done(input logic [7:0] got, input logic [7:0] want);
    cmp_count++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("Error at %0t: clocks got %h expected %h", $time, got, want);
    end
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // n of zero means a refused instruction with no execution phase
  task run(input logic [7:0] o, input logic [7:0] s, input logic two, input logic [31:0] e,
           input logic [7:0] n, input logic [1:0] k);
    sbd_fetch_model_i.push(o, addr);
    if (two)
      sbd_fetch_model_i.push(s, addr + 16'h0001);
    decQ.push_back(e);
    if (n != 8'h00)
      doneQ.push_back(n + {6'h00, k});
    if (n == 8'h00)
      for (t = 0; t < 60 && unsupported !== 1'b1; t++) @(posedge ref_clk) #1;
    else
    begin
      for (t = 0; t < 60 && fetchReady !== 1'b0; t++) @(posedge ref_clk) #1;
      busWait = (k != 2'h0);
      repeat (k) @(posedge ref_clk);
      #1 busWait = 1'b0;
      for (t = 0; t < 60 && instrDone !== 1'b1; t++) @(posedge ref_clk) #1;
    end
  endtask

  always @(negedge ref_clk)
  begin
    if (!rst && (decodeValid || unsupported))
      cmp_decode(unsupported ? 32'h80000000 : isAnd ? {17'h0, 1'b0, isAnd, isShortJump, andWide,
        andToFirstReg, andRegHi, andRegLo, execClocks} : {8'h00, 1'b0, isAnd, isShortJump,
        jumpTaken, execClocks, jumpTarget}, decQ.size() ? decQ.pop_front() : 32'hX);
    if (!rst && instrDone)
      cmp_done(elapsedClocks, doneQ.size() ? doneQ.pop_front() : 8'hXX);
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  // ***********************************************
  // random instruction stream
  // ***********************************************
  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      r2 = $random(seed);
      {carryFlag, zeroFlag, signFlag, overflowFlag, parityFlag, busWait} = r[5:0];
      loopCountRegister = r[6] ? 16'h0000 : r[31:16];
      addr = r2[31:16];
      op = {6'h08, r2[5:4]};
      if (i % 8 == 7 && r2[1])
        run(r2[2] ? 8'h6F : (r2[3] ? 8'hE2 : 8'h24), 8'h00, 1'b0, 32'h80000000, 8'h00, 2'h0);
      else if (i % 8 == 7)
        run(op, {1'b0, r2[14:8]}, 1'b1, 32'h80000000, 8'h00, 2'h0);
      else if (r2[3:0] < 4'h3)
      begin
        b1 = {2'h3, r2[13:8]};
        run(op, b1, 1'b1, {17'h0, 2'b01, 1'b0, op[0], op[1], b1[5:3], b1[2:0], 4'h1},
            8'h01, r2[15:14]);
      end
      else
      begin
        op = (r2[4] & r2[5] & r2[6]) ? 8'hE3 : {4'h7, r2[11:8]};
        tk = taken(op);
        tgt = addr + 16'h0002 + (tk ? {{8{r[15]}}, r[15:8]} : 16'h0000);
        ec = tk ? 4'h4 + {3'h0, tgt[0]} : 4'h1;
        run(op, r[15:8], 1'b1, {8'h00, 2'b00, 1'b1, tk, ec, tgt}, {4'h0, ec}, r2[13:12]);
      end
    end
    tally_and_finish;
  end
endmodule // sbd_decode_timing_test

// ===== dv/sbd_fetch_model.sv
// ***********************************************
// fetch queue model
// ***********************************************
module sbd_fetch_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        fetchReady,
  output logic             fetchValid,
  output logic [7:0]       fetchByte,
  output logic [15:0]      fetchAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] byteQ[$];
  integer      seed = 32'hF89CD684;

  task push(input logic [7:0] b, input logic [15:0] a);
    byteQ.push_back({a, b});
  endtask

  initial
  begin
    fetchValid = 1'b0;
    fetchByte = 8'h00;
    fetchAddr = 16'h0000;
  end

  // an offered byte is held until taken; idle lines toggle so stale data never looks valid
  always @(posedge ref_clk)
  begin : step
    logic took;
    took = fetchValid && fetchReady && !rst;
    if (took)
      void'(byteQ.pop_front());
    #1;
    if (took || !fetchValid)
    begin
      if (byteQ.size() != 0 && $random(seed) % 4 != 0)
      begin
        fetchValid = 1'b1;
        {fetchAddr, fetchByte} = byteQ[0];
      end
      else
      begin
        fetchValid = 1'b0;
        fetchByte = ~fetchByte;
        fetchAddr = ~fetchAddr;
      end
    end
  end
endmodule // sbd_fetch_model

// ===== logic/sbd_cond_eval.v
`include "sbd_consts.vh"

// ***********************************************
// branch condition evaluation, purely combinational
// ***********************************************
module sbd_cond_eval #(
  parameter CNT_W = 16
) (
  input  wire [7:0]       opcode,
  input  wire             carryFlag,
  input  wire             zeroFlag,
  input  wire             signFlag,
  input  wire             overflowFlag,
  input  wire             parityFlag,
  input  wire [CNT_W-1:0] loopCountRegister,
  output reg              isShortJump,
  output reg              jumpTaken
);

  reg baseCond;

  // even 7x codes test the plain condition, odd 7x codes its inverse; E3 tests the count for zero
  always @*
  begin
    case (opcode[3:1])
      3'h0:    baseCond = overflowFlag;
      3'h1:    baseCond = carryFlag;
      3'h2:    baseCond = zeroFlag;
      3'h3:    baseCond = carryFlag | zeroFlag;
      3'h4:    baseCond = signFlag;
      3'h5:    baseCond = parityFlag;
      3'h6:    baseCond = signFlag ^ overflowFlag;
      3'h7:    baseCond = (signFlag ^ overflowFlag) | zeroFlag;
      default: baseCond = 1'b0;
    endcase
  end

  always @*
  begin
    isShortJump = 1'b0;
    jumpTaken   = 1'b0;
    if (opcode[7:4] == `SBD_JCC_HIGH)
    begin
      isShortJump = 1'b1;
      jumpTaken   = baseCond ^ opcode[0];
    end
    else if (opcode == `SBD_JCOUNT_ZERO)
    begin
      isShortJump = 1'b1;
      jumpTaken   = (loopCountRegister == {CNT_W{1'b0}});
    end
  end

endmodule // sbd_cond_eval

// ===== logic/sbd_consts.vh
`ifndef SBD_CONSTS_VH
`define SBD_CONSTS_VH

// ***********************************************
// opcode patterns
// ***********************************************
`define SBD_AND_TO_RM     7'h11
`define SBD_AND_TO_REG    7'h10
`define SBD_JCC_HIGH      4'h7
`define SBD_JCOUNT_ZERO   8'hE3
`define SBD_MODE_REGREG   2'h3

// ***********************************************
// field positions
// ***********************************************
`define SBD_W_BIT         0
`define SBD_D_BIT         1
`define SBD_MODE_HI       7
`define SBD_MODE_LO       6
`define SBD_REGA_HI       5
`define SBD_REGA_LO       3
`define SBD_REGB_HI       2
`define SBD_REGB_LO       0

// ***********************************************
// timing counts in clocks
// ***********************************************
`define SBD_CLK_AND       4'h1
`define SBD_CLK_FALL      4'h1
`define SBD_CLK_TAKEN     4'h4
`define SBD_CLK_ODD_EXTRA 4'h1

// ***********************************************
// reset values and state codes
// ***********************************************
`define SBD_RST_ADDR      16'h0000
`define SBD_ST_OPCODE     2'h0
`define SBD_ST_OPERAND    2'h1
`define SBD_ST_EXEC       2'h2

`endif

// ===== logic/sbd_decode_timing.v
`include "sbd_consts.vh"

module sbd_decode_timing #(
  parameter ADDR_W = 16,
  parameter CNT_W  = 16
) (
  input  wire              ref_clk,
  input  wire              rst,
  input  wire              fetchValid,
  input  wire [7:0]        fetchByte,
  input  wire [ADDR_W-1:0] fetchAddr,
  output wire              fetchReady,
  input  wire              carryFlag,
  input  wire              zeroFlag,
  input  wire              signFlag,
  input  wire              overflowFlag,
  input  wire              parityFlag,
  input  wire [CNT_W-1:0]  loopCountRegister,
  input  wire              busWait,
  output reg               decodeValid,
  output reg               isAnd,
  output reg               andWide,
  output reg               andToFirstReg,
  output reg  [2:0]        andRegHi,
  output reg  [2:0]        andRegLo,
  output reg               isShortJump,
  output reg               jumpTaken,
  output reg  [ADDR_W-1:0] jumpTarget,
  output reg  [3:0]        execClocks,
  output reg               unsupported,
  output reg               instrDone,
  output reg  [7:0]        elapsedClocks,
  output wire              busy
);

  // ***********************************************
  // state and storage
  // ***********************************************
  reg [1:0]        state_reg;
  reg [1:0]        state_next;
  reg [7:0]        opcode_reg;
  reg [ADDR_W-1:0] opAddr_reg;
  reg [3:0]        remain_reg;
  reg [3:0]        remain_next;
  reg [7:0]        elapsed_reg;
  reg [7:0]        elapsed_next;

  wire             condIsJump;
  wire             condTaken;
  wire             takeByte;
  wire             firstIsAnd;
  wire             heldIsAnd;
  wire [ADDR_W-1:0] nextInstrAddr;
  wire [ADDR_W-1:0] offsetExt;
  wire [ADDR_W-1:0] targetAddr;
  wire [3:0]        jumpCost;

  // ***********************************************
  // condition check
  // ***********************************************
  // flags are sampled when the offset byte arrives, so a flag
  // update from the previous instruction is already visible
  sbd_cond_eval #(
    .CNT_W (CNT_W)
  ) u_cond (
    .opcode            (opcode_reg),
    .carryFlag         (carryFlag),
    .zeroFlag          (zeroFlag),
    .signFlag          (signFlag),
    .overflowFlag      (overflowFlag),
    .parityFlag        (parityFlag),
    .loopCountRegister (loopCountRegister),
    .isShortJump       (condIsJump),
    .jumpTaken         (condTaken)
  );

  // ***********************************************
  // byte handshake
  // ***********************************************
  // no bytes accepted while an instruction is timing out
  assign fetchReady = (state_reg != `SBD_ST_EXEC);
  assign busy       = (state_reg != `SBD_ST_OPCODE);
  assign takeByte   = fetchValid & fetchReady;

  assign firstIsAnd = (fetchByte[7:1] == `SBD_AND_TO_RM) |
                      (fetchByte[7:1] == `SBD_AND_TO_REG);
  assign heldIsAnd  = (opcode_reg[7:1] == `SBD_AND_TO_RM) |
                      (opcode_reg[7:1] == `SBD_AND_TO_REG);

  // ***********************************************
  // jump target and cost
  // ***********************************************
  // the jump is two bytes, so the follower sits two past the opcode
  assign nextInstrAddr = opAddr_reg + {{(ADDR_W-2){1'b0}}, 2'h2};
  assign offsetExt     = {{(ADDR_W-8){fetchByte[7]}}, fetchByte};
  assign targetAddr    = nextInstrAddr + offsetExt;

  // odd targets need an extra fetch cycle to realign the queue
  assign jumpCost = !condTaken ? `SBD_CLK_FALL :
                    (targetAddr[0] ? (`SBD_CLK_TAKEN + `SBD_CLK_ODD_EXTRA)
                                   : `SBD_CLK_TAKEN);

  // ***********************************************
  // sequencer
  // ***********************************************
  always @*
  begin
    state_next   = state_reg;
    remain_next  = remain_reg;
    elapsed_next = elapsed_reg;
    case (state_reg)
      `SBD_ST_OPCODE:
      begin
        if (takeByte)
        begin
          if (firstIsAnd || fetchByte[7:4] == `SBD_JCC_HIGH ||
              fetchByte == `SBD_JCOUNT_ZERO)
          begin
            state_next = `SBD_ST_OPERAND;
          end
        end
      end
      `SBD_ST_OPERAND:
      begin
        if (takeByte)
        begin
          elapsed_next = 8'h00;
          if (heldIsAnd)
          begin
            // memory forms are not handled here
            if (fetchByte[7:6] == `SBD_MODE_REGREG)
            begin
              remain_next = `SBD_CLK_AND;
              state_next  = `SBD_ST_EXEC;
            end
            else
            begin
              state_next = `SBD_ST_OPCODE;
            end
          end
          else
          begin
            remain_next = jumpCost;
            state_next  = `SBD_ST_EXEC;
          end
        end
      end
      `SBD_ST_EXEC:
      begin
        elapsed_next = elapsed_reg + 8'h01;
        // a wait cycle stretches the instruction without consuming a clock
        if (!busWait)
        begin
          remain_next = remain_reg - 4'h1;
          if (remain_reg == 4'h1)
          begin
            state_next = `SBD_ST_OPCODE;
          end
        end
      end
      default:
      begin
        state_next = `SBD_ST_OPCODE;
      end
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg   <= `SBD_ST_OPCODE;
      opcode_reg  <= 8'h00;
      opAddr_reg  <= `SBD_RST_ADDR;
      remain_reg  <= 4'h0;
      elapsed_reg <= 8'h00;
    end
    else
    begin
      state_reg   <= state_next;
      remain_reg  <= remain_next;
      elapsed_reg <= elapsed_next;
      if (takeByte && state_reg == `SBD_ST_OPCODE)
      begin
        opcode_reg <= fetchByte;
        opAddr_reg <= fetchAddr;
      end
    end
  end

  // ***********************************************
  // decode results
  // ***********************************************
  // results stand until the next decode; the strobes last one cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      decodeValid   <= 1'b0;
      isAnd         <= 1'b0;
      andWide       <= 1'b0;
      andToFirstReg <= 1'b0;
      andRegHi      <= 3'h0;
      andRegLo      <= 3'h0;
      isShortJump   <= 1'b0;
      jumpTaken     <= 1'b0;
      jumpTarget    <= `SBD_RST_ADDR;
      execClocks    <= 4'h0;
      unsupported   <= 1'b0;
    end
    else
    begin
      decodeValid <= 1'b0;
      unsupported <= 1'b0;
      if (takeByte && state_reg == `SBD_ST_OPCODE)
      begin
        // anything outside this block's opcode set is flagged and dropped
        if (!(firstIsAnd || fetchByte[7:4] == `SBD_JCC_HIGH ||
              fetchByte == `SBD_JCOUNT_ZERO))
        begin
          unsupported <= 1'b1;
        end
      end
      else if (takeByte && state_reg == `SBD_ST_OPERAND)
      begin
        if (heldIsAnd)
        begin
          if (fetchByte[7:6] == `SBD_MODE_REGREG)
          begin
            decodeValid   <= 1'b1;
            isAnd         <= 1'b1;
            isShortJump   <= 1'b0;
            jumpTaken     <= 1'b0;
            andWide       <= opcode_reg[`SBD_W_BIT];
            andToFirstReg <= opcode_reg[`SBD_D_BIT];
            andRegHi      <= fetchByte[`SBD_REGA_HI:`SBD_REGA_LO];
            andRegLo      <= fetchByte[`SBD_REGB_HI:`SBD_REGB_LO];
            execClocks    <= `SBD_CLK_AND;
          end
          else
          begin
            unsupported <= 1'b1;
          end
        end
        else if (condIsJump)
        begin
          decodeValid <= 1'b1;
          isAnd       <= 1'b0;
          isShortJump <= 1'b1;
          jumpTaken   <= condTaken;
          jumpTarget  <= condTaken ? targetAddr : nextInstrAddr;
          execClocks  <= jumpCost;
        end
      end
    end
  end

  // ***********************************************
  // completion
  // ***********************************************
  // elapsed count includes wait cycles, so it can exceed execClocks
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      instrDone     <= 1'b0;
      elapsedClocks <= 8'h00;
    end
    else
    begin
      instrDone <= 1'b0;
      if (state_reg == `SBD_ST_EXEC && !busWait && remain_reg == 4'h1)
      begin
        instrDone     <= 1'b1;
        elapsedClocks <= elapsed_reg + 8'h01;
      end
    end
  end

endmodule // sbd_decode_timing
